// *** design/sbie_alu.sv ***
`timescale 1ns/10ps
// Registered result stage: computes value and zero test for one operation
module sbie_alu
    import sbie_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sbie_op_t op_i,
    input wire logic [SBIE_DW-1:0] acc_i,
    input wire logic [SBIE_DW-1:0] reg_i,
    input wire logic [SBIE_DW-1:0] imm_i,
    output logic [SBIE_DW-1:0] res_o,
    output logic zero_o
);
    logic [SBIE_DW-1:0] next_res;

    // Eight-bit arithmetic wraps modulo 256 by construction
    always_comb begin
        case (op_i)
            SBIE_DECSKIP: next_res = reg_i - SBIE_ONE;
            SBIE_INCSKIP, SBIE_INC: next_res = reg_i + SBIE_ONE;
            SBIE_ORIMM: next_res = acc_i | imm_i;
            SBIE_ORREG: next_res = acc_i | reg_i;
            default: next_res = acc_i;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_o <= SBIE_ACC_RST;
            zero_o <= 1'b0;
        end else begin
            res_o <= next_res;
            zero_o <= (next_res == SBIE_ACC_RST);
        end
    end
endmodule

// *** design/sbie_exec.sv ***
`timescale 1ns/10ps
// Overview of operation
// RULE_01 - Decrement-skip subtracts one from the register and sends it to acc (d=0) or register (d=1), flags untouched.
// RULE_02 - A zero decrement result turns the next instruction into an idle cycle, two cycles in all.
// RULE_03 - A zero increment-skip result turns the next instruction into an idle cycle, two cycles in all.
// RULE_04 - Both increments add one and route by the target bit; only the plain increment updates the zero flag.
// RULE_05 - The jump loads its 11-bit immediate into program counter bits 10 to 0, flags untouched.
// RULE_06 - The jump fills program counter bits 14 to 11 from latch bits 6 to 3.
// RULE_07 - The jump takes two cycles and discards the already fetched instruction.
// RULE_08 - OR immediate ors acc with the 8-bit immediate into acc and updates the zero flag.
// RULE_09 - OR register ors acc with the register, routes by the target bit and updates the zero flag.
// RULE_10 - The zero flag is set when the wrapped 8-bit result is zero and cleared otherwise.
module sbie_exec
    import sbie_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic INSTR_VALID_I,
    input wire logic [SBIE_IW-1:0] INSTR_I,
    input wire logic [SBIE_DW-1:0] REG_RDATA_I,
    input wire logic [SBIE_DW-1:0] UPPER_TARGET_LATCH_I,
    output logic [SBIE_DW-1:0] ACC_O,
    output logic RESULT_NULL_FLAG_O,
    output logic REG_WE_O,
    output logic [SBIE_FW-1:0] REG_WADDR_O,
    output logic [SBIE_DW-1:0] REG_WDATA_O,
    output logic PC_LOAD_O,
    output logic [SBIE_PCW-1:0] PC_O,
    output logic IDLE_CYCLE_O
);
    sbie_op_t op;
    sbie_op_t op_q;
    logic target_q;
    logic [SBIE_FW-1:0] addr_q;
    logic [SBIE_DW-1:0] alu_res;
    logic alu_zero;
    logic squash;

    // Decoding used for the opcode table
    function automatic sbie_op_t decode(input logic [SBIE_IW-1:0] w);
        if (w[13:11] == SBIE_OP_JUMP) return SBIE_JUMP;
        case (w[13:8])
            SBIE_OP_DECSKIP: return SBIE_DECSKIP;
            SBIE_OP_INCSKIP: return SBIE_INCSKIP;
            SBIE_OP_INC: return SBIE_INC;
            SBIE_OP_ORREG: return SBIE_ORREG;
            SBIE_OP_ORIMM: return SBIE_ORIMM;
            default: return SBIE_NONE;
        endcase
    endfunction

    // A squashed slot executes as an idle cycle, never as the fetched word
    always_comb begin
        if (INSTR_VALID_I && !squash) begin
            op = decode(INSTR_I);
        end else begin
            op = SBIE_NONE;
        end
    end

    sbie_alu u_alu (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .op_i(op),
        .acc_i(ACC_O),
        .reg_i(REG_RDATA_I),
        .imm_i(INSTR_I[SBIE_DW-1:0]),
        .res_o(alu_res),
        .zero_o(alu_zero)
    );

    // Operation context held for the write-back stage
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            op_q <= SBIE_NONE;
            target_q <= 1'b0;
            addr_q <= '0;
        end else begin
            op_q <= op;
            target_q <= INSTR_I[SBIE_D_BIT];
            addr_q <= INSTR_I[SBIE_FW-1:0];
        end
    end

    // Squash the next slot: skip on zero, or a jump always
    always_comb begin
        squash = 1'b0;
        if (op_q == SBIE_DECSKIP && alu_zero) squash = 1'b1; // RULE_02
        if (op_q == SBIE_INCSKIP && alu_zero) squash = 1'b1; // RULE_03
        if (op_q == SBIE_JUMP) squash = 1'b1; // RULE_07
    end

    // Idle pulse only for a valid slot; an empty slot has nothing to replace
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IDLE_CYCLE_O <= 1'b0;
        end else begin
            IDLE_CYCLE_O <= squash && INSTR_VALID_I;
        end
    end

    // Accumulator write-back; register-target results leave it alone
    // No bypass: the op right behind sees the old acc, so dependent ops need a gap
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ACC_O <= SBIE_ACC_RST;
        end else begin
            case (op_q)
                SBIE_DECSKIP, SBIE_INCSKIP, SBIE_INC, SBIE_ORREG: begin
                    if (!target_q) ACC_O <= alu_res; // RULE_01 RULE_04 RULE_09
                end
                SBIE_ORIMM: ACC_O <= alu_res; // RULE_08
                default: ACC_O <= ACC_O;
            endcase
        end
    end

    // Register write port, one pulse per register-target result
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_WE_O <= 1'b0;
            REG_WADDR_O <= '0;
            REG_WDATA_O <= SBIE_ACC_RST;
        end else begin
            REG_WE_O <= target_q && (op_q == SBIE_DECSKIP || op_q == SBIE_INCSKIP ||
                op_q == SBIE_INC || op_q == SBIE_ORREG); // RULE_01 RULE_04 RULE_09
            REG_WADDR_O <= addr_q;
            REG_WDATA_O <= alu_res;
        end
    end

    // Zero flag: skip variants and the jump leave it untouched
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RESULT_NULL_FLAG_O <= 1'b0;
        end else if (op_q == SBIE_INC || op_q == SBIE_ORIMM || op_q == SBIE_ORREG) begin
            RESULT_NULL_FLAG_O <= alu_zero; // RULE_10 RULE_04 RULE_08 RULE_09
        end
    end

    // Jump target assembled at decode time; latch is same-domain core logic
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PC_LOAD_O <= 1'b0;
            PC_O <= SBIE_PC_RST;
        end else begin
            PC_LOAD_O <= (op == SBIE_JUMP);
            if (op == SBIE_JUMP) begin
                PC_O <= {UPPER_TARGET_LATCH_I[SBIE_LATCH_HI:SBIE_LATCH_LO], // RULE_06
                    INSTR_I[SBIE_KW-1:0]}; // RULE_05
            end
        end
    end

    // Checks follow the pipeline: squash and jump target one cycle after issue, other results two cycles after
    a_skip_dec: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_02
        (op == SBIE_DECSKIP && REG_RDATA_I == SBIE_ONE) |=> squash)
        else $error("zero decrement did not squash next slot");
    a_skip_inc: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_03
        (op == SBIE_INCSKIP && REG_RDATA_I == 8'hFF) |=> squash)
        else $error("zero increment did not squash next slot");
    a_noskip_dec: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_02
        (op == SBIE_DECSKIP && REG_RDATA_I != SBIE_ONE) |=> !squash)
        else $error("nonzero decrement squashed next slot");
    a_jump_target: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_05
        (op == SBIE_JUMP) |=> (PC_LOAD_O && PC_O[10:0] == $past(INSTR_I[10:0])))
        else $error("jump low bits wrong");
    a_jump_upper: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_06
        (op == SBIE_JUMP) |=> (PC_O[14:11] == $past(UPPER_TARGET_LATCH_I[6:3])))
        else $error("jump upper bits wrong");
    a_jump_discard: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_07
        (op == SBIE_JUMP) |=> (op == SBIE_NONE))
        else $error("slot after jump not discarded");
    a_dec_value: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_01
        (op == SBIE_DECSKIP && !INSTR_I[7]) |=> ##1 (ACC_O == $past(REG_RDATA_I, 2) - 8'h01))
        else $error("decrement result wrong");
    a_flag_kept: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_04
        (op == SBIE_INCSKIP || op == SBIE_DECSKIP || op == SBIE_JUMP) |=> ##1 $stable(RESULT_NULL_FLAG_O))
        else $error("flag changed by flag-neutral op");
    a_orimm_flag: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_08
        (op == SBIE_ORIMM) |=> ##1 (RESULT_NULL_FLAG_O == ((($past(ACC_O, 2)) | $past(INSTR_I[7:0], 2)) == 8'h00)))
        else $error("or immediate flag wrong");
    a_orreg_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_09
        (op == SBIE_ORREG && INSTR_I[7]) |=> ##1 (REG_WE_O && REG_WDATA_O == ($past(ACC_O, 2) | $past(REG_RDATA_I, 2))))
        else $error("or register write-back wrong");

    // Sequences for the multi-step behaviours below
    // A skip op whose wrapped result came out zero, squashing the next slot
    sequence s_skip_zero;
        (op == SBIE_DECSKIP || op == SBIE_INCSKIP) ##1 alu_zero;
    endsequence

    // A jump followed by a slot that the fetch side still marked valid
    sequence s_jump_slot;
        (op == SBIE_JUMP) ##1 INSTR_VALID_I;
    endsequence

    // Register-target increment, either variant
    sequence s_inc_to_reg;
        (op == SBIE_INC || op == SBIE_INCSKIP) && INSTR_I[SBIE_D_BIT];
    endsequence

    // Idle pulse, skip, flag and write-back checks; three are built on the sequences above
    a_skip_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_02 RULE_03
        s_skip_zero ##0 INSTR_VALID_I |=> IDLE_CYCLE_O)
        else $error("squashed slot gave no idle pulse");
    a_noskip_inc: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_03
        (op == SBIE_INCSKIP && REG_RDATA_I != 8'hFF) |=> !squash)
        else $error("nonzero increment squashed next slot");
    a_jump_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_07
        s_jump_slot |=> (IDLE_CYCLE_O && !PC_LOAD_O))
        else $error("slot after jump not replaced by idle cycle");
    a_inc_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_04
        s_inc_to_reg |=> ##1 (REG_WE_O && REG_WDATA_O == ($past(REG_RDATA_I, 2) + 8'h01)
            && REG_WADDR_O == $past(INSTR_I[SBIE_FW-1:0], 2)))
        else $error("increment write-back wrong");
    a_inc_flag: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_10
        (op == SBIE_INC) |=> ##1 (RESULT_NULL_FLAG_O == (($past(REG_RDATA_I, 2) + 8'h01) == 8'h00)))
        else $error("increment zero flag wrong");
    a_orimm_value: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_08
        (op == SBIE_ORIMM) |=> ##1 (ACC_O == ($past(ACC_O, 2) | $past(INSTR_I[7:0], 2))))
        else $error("or immediate result wrong");
    a_reg_keeps_acc: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RULE_01
        (op == SBIE_DECSKIP && INSTR_I[SBIE_D_BIT]) |=> ##1 $stable(ACC_O))
        else $error("register-target decrement changed acc");
endmodule

// *** design/sbie_pkg.sv ***
package sbie_pkg;
    // Opcode field layout of the 14-bit instruction word
    localparam int SBIE_IW = 14;
    localparam int SBIE_DW = 8;
    localparam int SBIE_FW = 7;
    localparam int SBIE_PCW = 15;
    localparam int SBIE_KW = 11;
    localparam int SBIE_D_BIT = 7;
    localparam int SBIE_LATCH_LO = 3;
    localparam int SBIE_LATCH_HI = 6;
    // Operation encodings, upper six bits of the word
    localparam logic [5:0] SBIE_OP_DECSKIP = 6'h0B;
    localparam logic [5:0] SBIE_OP_INCSKIP = 6'h0F;
    localparam logic [5:0] SBIE_OP_INC = 6'h0A;
    localparam logic [5:0] SBIE_OP_ORREG = 6'h04;
    localparam logic [5:0] SBIE_OP_ORIMM = 6'h38;
    // Jump uses the top three bits only
    localparam logic [2:0] SBIE_OP_JUMP = 3'h5;
    localparam logic [SBIE_DW-1:0] SBIE_ACC_RST = 8'h00;
    localparam logic [SBIE_PCW-1:0] SBIE_PC_RST = 15'h0000;
    localparam logic [SBIE_DW-1:0] SBIE_ONE = 8'h01;
    typedef enum logic [2:0] {
        SBIE_NONE, SBIE_DECSKIP, SBIE_INCSKIP, SBIE_JUMP, SBIE_ORIMM, SBIE_INC, SBIE_ORREG
    } sbie_op_t;
endpackage

// *** testbench/sbie_exec_tb_top.sv ***
`timescale 1ns/10ps
// Table of single ops, then skip, jump and reset cases
module sbie_exec_tb_top
    import sbie_pkg::*;
;
    typedef struct {logic [13:0] w; logic [7:0] acc; logic z; logic we; logic [6:0] wa; logic [7:0] wd;} sbie_row_t;
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0, we, pcl, idle, z;
    logic [13:0] ins = 14'h0000;
    logic [7:0] rd, latch = 8'h00, acc, wd;
    logic [6:0] wa;
    logic [14:0] pc;
    int mismatches = 0, tests_run = 0;
    // Expected state is carried by hand from row to row
    sbie_row_t rows [10] = '{'{14'h3800, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00}, '{14'h38A5, 8'hA5, 1'b0, 1'b0, 7'h00, 8'h00},
        '{14'h0A05, 8'h06, 1'b0, 1'b0, 7'h00, 8'h00}, '{14'h0490, 8'h06, 1'b0, 1'b1, 7'h10, 8'h16},
        '{14'h0B81, 8'h06, 1'b0, 1'b1, 7'h01, 8'h00}, '{14'h0A7F, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00},
        '{14'h0F04, 8'h05, 1'b1, 1'b0, 7'h00, 8'h00}, '{14'h0B03, 8'h02, 1'b1, 1'b0, 7'h00, 8'h00},
        '{14'h0400, 8'h02, 1'b0, 1'b0, 7'h00, 8'h00}, '{14'h0A86, 8'h02, 1'b0, 1'b1, 7'h06, 8'h07}};
    always #5 clk = ~clk;
    sbie_exec i_dut (.REF_CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins), .REG_RDATA_I(rd),
        .UPPER_TARGET_LATCH_I(latch), .ACC_O(acc), .RESULT_NULL_FLAG_O(z), .REG_WE_O(we), .REG_WADDR_O(wa),
        .REG_WDATA_O(wd), .PC_LOAD_O(pcl), .PC_O(pc), .IDLE_CYCLE_O(idle));
    sbie_regfile_model i_regs (.clk_i(clk), .raddr_i(ins[6:0]), .we_i(we), .waddr_i(wa), .wdata_i(wd), .rdata_o(rd));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Two slots back to back; returns just after the edge of slot two
    task automatic issue2(input logic [13:0] a, input logic vb, input logic [13:0] b);
        @(posedge clk);
        vld <= 1'b1;
        ins <= a;
        @(posedge clk);
        vld <= vb;
        ins <= b;
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("acc after reset", 16'(acc), 16'h0000);
        chk("pc after reset", 16'(pc), 16'h0000);
        $display("Power-on reset done");
        foreach (rows[i]) begin
            issue2(rows[i].w, 1'b0, 14'h0000);
            chk("acc", 16'(acc), 16'(rows[i].acc));
            chk("zero flag", 16'(z), 16'(rows[i].z));
            chk("write pulse", 16'(we), 16'(rows[i].we));
            if (rows[i].we) chk("write", {1'b0, wa, wd}, {1'b0, rows[i].wa, rows[i].wd});
            chk("idle", 16'(idle), 16'h0000);
            $display("Row %0d done", i);
        end
        // Non-zero decrement lets the next op run
        issue2(14'h0B03, 1'b1, 14'h3880);
        chk("idle", 16'(idle), 16'h0000);
        step();
        chk("acc", 16'(acc), 16'h0082);
        $display("Skip not taken done");
        // Wrapping increment squashes the next op
        issue2(14'h0F7F, 1'b1, 14'h3840);
        chk("idle", 16'(idle), 16'h0001);
        chk("acc", 16'(acc), 16'h0000);
        step();
        chk("acc squashed", 16'(acc), 16'h0000);
        chk("zero flag", 16'(z), 16'h0000);
        $display("Skip taken done");
        // Only latch bits 6:3 reach the top of the target
        @(posedge clk);
        latch <= 8'h8B;
        vld <= 1'b1;
        ins <= 14'h2D55;
        @(posedge clk);
        ins <= 14'h38FF;
        #1;
        chk("pc load", 16'(pcl), 16'h0001);
        chk("pc", 16'(pc), 16'h0D55);
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("idle", 16'(idle), 16'h0001);
        chk("pc load once", 16'(pcl), 16'h0000);
        step();
        chk("acc", 16'(acc), 16'h0000);
        chk("zero flag", 16'(z), 16'h0000);
        $display("Jump done");
        // Reset in mid-run clears the state
        @(posedge clk);
        rst <= 1'b1;
        step();
        chk("pc after reset", 16'(pc), 16'h0000);
        chk("idle after reset", 16'(idle), 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        // First slot after release must execute normally
        issue2(14'h3800, 1'b0, 14'h0000);
        chk("acc after release", 16'(acc), 16'h0000);
        chk("zero flag after release", 16'(z), 16'h0001);
        $display("Reset done");
        close_out();
    end
endmodule

// *** testbench/sbie_regfile_model.sv ***
`timescale 1ns/10ps
// Data register file on the far side of the executor
module sbie_regfile_model
    import sbie_pkg::*;
(
    input wire logic clk_i,
    input wire logic [SBIE_FW-1:0] raddr_i,
    input wire logic we_i,
    input wire logic [SBIE_FW-1:0] waddr_i,
    input wire logic [SBIE_DW-1:0] wdata_i,
    output logic [SBIE_DW-1:0] rdata_o
);
    logic [SBIE_DW-1:0] mem [0:127];
    // Cells start at their own address; top cell all ones to reach the wrap
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i);
        end
        mem[127] = 8'hFF;
    end
    // Combinational read, valid in the issue cycle
    assign rdata_o = mem[raddr_i];
    // Write-back lands one edge after the pulse, before the next issue
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule
